// ===== core/cah_decode_core.v
// Purpose: execute compact ALU, high-register/branch and pc-relative load
// Assumes: instruction and its address issued over AXI4-Lite; load path on aclk
// Notes: one instruction under way at a time; busy refuses a new one
`timescale 1ns/1ps
`include "cah_regs.vh"
module cah_decode_core (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg load_req,
  output reg [31:0] load_addr,
  input wire [31:0] load_data,
  input wire load_valid,
  output wire busy,
  output reg instr_done,
  output reg branch_valid,
  output reg [31:0] branch_addr,
  output reg compact_state,
  output reg [3:0] cond_flags
);
  localparam ST_IDLE = 1'b0;
  localparam ST_RUN = 1'b1;
  localparam SH_LEFT = 2'h0;
  localparam SH_RLOG = 2'h1;
  localparam SH_RARI = 2'h2;
  localparam SH_ROT = 2'h3;

  // ****************************************
  // helper functions
  // ****************************************
  function [3:0] cah_rd_idx;
    input [15:0] i;
    begin
      if (i[15:10] == `CAH_FMT5_PAT) begin
        cah_rd_idx = {i[7], i[2:0]};
      end else if (i[15:11] == `CAH_FMT6_PAT) begin
        cah_rd_idx = {1'b0, i[10:8]};
      end else begin
        cah_rd_idx = {1'b0, i[2:0]};
      end
    end
  endfunction

  function [3:0] cah_src_idx;
    input [15:0] i;
    begin
      if (i[15:10] == `CAH_FMT5_PAT) begin
        cah_src_idx = {i[6], i[5:3]};
      end else begin
        cah_src_idx = {1'b0, i[5:3]};
      end
    end
  endfunction

  // returns {overflow, carry, sum}
  function [33:0] cah_add;
    input [31:0] a;
    input [31:0] b;
    input cin;
    reg [32:0] s;
    begin
      s = {1'b0, a} + {1'b0, b} + {32'h0, cin};
      cah_add = {(a[31] == b[31]) && (s[31] != a[31]), s};
    end
  endfunction

  // returns {carry out, result}; amount zero leaves value and carry alone
  function [32:0] cah_shift;
    input [1:0] kind;
    input [31:0] d;
    input [7:0] n;
    input cin;
    reg [63:0] w;
    reg [31:0] r;
    reg c;
    begin
      w = 64'h0;
      r = d;
      c = cin;
      if (n != 8'h00) begin
        case (kind)
          SH_LEFT: begin
            w = {32'h0, d} << n;
            r = w[31:0];
            c = w[32];
          end
          SH_RLOG: begin
            w = {d, 32'h0} >> n;
            r = w[63:32];
            c = w[31];
          end
          SH_RARI: begin
            w = {d, 32'h0};
            w = $signed(w) >>> n;
            r = w[63:32];
            c = w[31];
          end
          default: begin
            if (n[4:0] == 5'h00) begin
              c = d[31];
            end else begin
              w = {d, d} >> n[4:0];
              r = w[31:0];
              c = r[31];
            end
          end
        endcase
      end
      cah_shift = {c, r};
    end
  endfunction

  // multiply cycles: one plus one per significant multiplier byte group
  function [3:0] cah_mul_cyc;
    input [31:0] m;
    begin
      if (m[31:8] == 24'h0 || m[31:8] == 24'hff_ffff) begin
        cah_mul_cyc = `CAH_CYC_DP + 4'h1;
      end else if (m[31:16] == 16'h0 || m[31:16] == 16'hffff) begin
        cah_mul_cyc = `CAH_CYC_DP + 4'h2;
      end else if (m[31:24] == 8'h0 || m[31:24] == 8'hff) begin
        cah_mul_cyc = `CAH_CYC_DP + 4'h3;
      end else begin
        cah_mul_cyc = `CAH_CYC_DP + 4'h4;
      end
    end
  endfunction

  // ****************************************
  // state
  // ****************************************
  reg st_r;
  reg [3:0] cnt_r;
  reg [15:0] ir_r;
  reg [31:0] iaddr_r;
  reg [31:0] res_r;
  reg [31:0] result_r;
  reg [31:0] target_r;
  reg [3:0] cycles_r;
  reg unsup_r;
  reg wb_r;
  reg [3:0] widx_r;
  reg [3:0] fl_r;
  reg br_r;
  reg [31:0] bra_r;
  reg t_r;
  reg un_r;
  reg [3:0] ncyc_r;
  reg aw_full_r;
  reg w_full_r;
  reg [7:0] awaddr_r;
  reg [31:0] wdata_r;
  reg [3:0] wstrb_r;
  reg rp1_r;
  reg rp2_r;
  reg [7:0] araddr_r;
  wire [31:0] rf_a;
  wire [31:0] rf_b;

  assign busy = (st_r == ST_RUN);
  assign s_axi_awready = !aw_full_r && !s_axi_bvalid;
  assign s_axi_wready = !w_full_r && !s_axi_bvalid;
  assign s_axi_arready = !rp1_r && !rp2_r && !s_axi_rvalid;

  wire wr_do = aw_full_r && w_full_r && !s_axi_bvalid;
  wire wr_win = (awaddr_r[7:6] == `CAH_WIN_BASE);
  wire issue = wr_do && !busy && (awaddr_r == `CAH_OFF_INSTR);
  wire rd_win = (araddr_r[7:6] == `CAH_WIN_BASE);
  wire rd_step = rp1_r && !issue;

  // ****************************************
  // execute: operands and result of the first run cycle
  // ****************************************
  wire [3:0] rd_i = cah_rd_idx(ir_r);
  wire [3:0] src_i = cah_src_idx(ir_r);
  wire [31:0] pc_op = (iaddr_r + `CAH_PC_AHEAD) & `CAH_CLR_BIT0;
  wire [31:0] op_a = (rd_i == `CAH_PC_IDX) ? pc_op : rf_a;
  wire [31:0] op_b = (src_i == `CAH_PC_IDX) ? pc_op : rf_b;
  wire [31:0] ld_base = (iaddr_r + `CAH_PC_AHEAD) & `CAH_CLR_BIT1;
  wire [31:0] ld_ea = ld_base + {22'h0, ir_r[7:0], 2'b00};
  wire c_in = cond_flags[1];

  reg [31:0] res_c;
  reg [3:0] fl_c;
  reg wb_c;
  reg br_c;
  reg [31:0] bra_c;
  reg t_c;
  reg [3:0] ncyc_c;
  reg ld_c;
  reg un_c;
  reg [33:0] ad;
  reg [32:0] sh;
  reg arith;

  always @* begin
    res_c = op_a;
    fl_c = cond_flags;
    wb_c = 1'b0;
    br_c = 1'b0;
    bra_c = target_r;
    t_c = compact_state;
    ncyc_c = `CAH_CYC_DP;
    ld_c = 1'b0;
    un_c = 1'b0;
    ad = 34'h0;
    sh = 33'h0;
    arith = 1'b0;
    if (ir_r[15:10] == `CAH_FMT4_PAT) begin
      wb_c = 1'b1;
      case (ir_r[9:6])
        `CAH_OP_AND: res_c = op_a & op_b;
        `CAH_OP_XOR: res_c = op_a ^ op_b;
        `CAH_OP_OR: res_c = op_a | op_b;
        `CAH_OP_ANDN: res_c = op_a & ~op_b;
        `CAH_OP_NOT: res_c = ~op_b;
        `CAH_OP_SHL, `CAH_OP_SHR, `CAH_OP_SAR, `CAH_OP_ROTR: begin
          case (ir_r[9:6])
            `CAH_OP_SHL: sh = cah_shift(SH_LEFT, op_a, op_b[7:0], c_in);
            `CAH_OP_SHR: sh = cah_shift(SH_RLOG, op_a, op_b[7:0], c_in);
            `CAH_OP_SAR: sh = cah_shift(SH_RARI, op_a, op_b[7:0], c_in);
            default: sh = cah_shift(SH_ROT, op_a, op_b[7:0], c_in);
          endcase
          res_c = sh[31:0];
          fl_c[1] = sh[32];
          ncyc_c = `CAH_CYC_REGSHIFT;
        end
        `CAH_OP_ADC: begin
          ad = cah_add(op_a, op_b, c_in);
          arith = 1'b1;
        end
        `CAH_OP_SUBC: begin
          ad = cah_add(op_a, ~op_b, c_in);
          arith = 1'b1;
        end
        `CAH_OP_TEST: begin
          res_c = op_a & op_b;
          wb_c = 1'b0;
        end
        `CAH_OP_RSUB: begin
          ad = cah_add(32'h0, ~op_b, 1'b1);
          arith = 1'b1;
        end
        `CAH_OP_CSUB: begin
          ad = cah_add(op_a, ~op_b, 1'b1);
          arith = 1'b1;
          wb_c = 1'b0;
        end
        `CAH_OP_CADD: begin
          ad = cah_add(op_a, op_b, 1'b0);
          arith = 1'b1;
          wb_c = 1'b0;
        end
        default: begin
          res_c = op_b * op_a;
          ncyc_c = cah_mul_cyc(op_a);
        end
      endcase
      if (arith) begin
        res_c = ad[31:0];
        fl_c[1:0] = {ad[32], ad[33]};
      end
      fl_c[3] = res_c[31];
      fl_c[2] = (res_c == 32'h0);
    end else if (ir_r[15:10] == `CAH_FMT5_PAT) begin
      case (ir_r[9:8])
        `CAH_HOP_ADD, `CAH_HOP_COPY: begin
          res_c = (ir_r[9:8] == `CAH_HOP_ADD) ? op_a + op_b : op_b;
          if (rd_i == `CAH_PC_IDX) begin
            br_c = 1'b1;
            bra_c = res_c & `CAH_CLR_BIT0;
            ncyc_c = `CAH_CYC_PCWRITE;
          end else begin
            wb_c = 1'b1;
          end
        end
        `CAH_HOP_CSUB: begin
          ad = cah_add(op_a, ~op_b, 1'b1);
          res_c = ad[31:0];
          fl_c = {ad[31], ad[31:0] == 32'h0, ad[32], ad[33]};
        end
        default: begin
          br_c = 1'b1;
          bra_c = op_b & `CAH_CLR_BIT0;
          t_c = op_b[0];
          res_c = op_b;
          ncyc_c = `CAH_CYC_PCWRITE;
        end
      endcase
    end else if (ir_r[15:11] == `CAH_FMT6_PAT) begin
      ld_c = 1'b1;
      wb_c = 1'b1;
      res_c = ld_ea;
      ncyc_c = `CAH_CYC_LOAD;
    end else begin
      un_c = 1'b1;
    end
  end

  // ****************************************
  // completion and writeback
  // ****************************************
  wire first = busy && (cnt_r == 4'h1);
  wire [3:0] need = first ? ncyc_c : ncyc_r;
  wire ld_pend = first ? ld_c : load_req;
  wire fin = busy && (cnt_r >= need) && (!ld_pend || load_valid);
  wire [31:0] fin_res = (load_req && load_valid) ? load_data : (first ? res_c : res_r);
  wire fin_wb = first ? wb_c : wb_r;
  wire fin_br = first ? br_c : br_r;
  wire [31:0] fin_bra = first ? bra_c : bra_r;
  wire [3:0] fin_fl = first ? fl_c : fl_r;
  wire fin_t = first ? t_c : t_r;
  wire fin_un = first ? un_c : un_r;
  wire [3:0] fin_idx = first ? rd_i : widx_r;
  wire rf_we = (fin && fin_wb) || (wr_do && wr_win && !busy);
  wire [3:0] rf_wa = busy ? fin_idx : awaddr_r[5:2];
  wire [31:0] rf_wd = busy ? fin_res : wdata_r;
  wire [3:0] ra_idx = issue ? cah_rd_idx(wdata_r[15:0]) : araddr_r[5:2];

  cah_regfile #(
    .DW(32),
    .AW(4)
  ) u_rf (
    .aclk(aclk),
    .re_a(issue || rd_step),
    .addr_a(ra_idx),
    .rdata_a(rf_a),
    .re_b(issue),
    .addr_b(cah_src_idx(wdata_r[15:0])),
    .rdata_b(rf_b),
    .we(rf_we),
    .waddr(rf_wa),
    .wdata(rf_wd)
  );

  function [31:0] cah_strb;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] s;
    integer k;
    begin
      cah_strb = old;
      for (k = 0; k < 4; k = k + 1) begin
        if (s[k]) begin
          cah_strb[8*k +: 8] = nw[8*k +: 8];
        end
      end
    end
  endfunction

  wire [31:0] status_w = {cond_flags, 25'h0, unsup_r, compact_state, busy};
  wire [31:0] status_nw = cah_strb(status_w, wdata_r, wstrb_r);

  always @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= ST_IDLE;
      cnt_r <= 4'h0;
      ir_r <= 16'h0;
      iaddr_r <= `CAH_RST_WORD;
      res_r <= `CAH_RST_WORD;
      result_r <= `CAH_RST_WORD;
      target_r <= `CAH_RST_WORD;
      cycles_r <= 4'h0;
      unsup_r <= 1'b0;
      {wb_r, br_r, t_r, un_r} <= 4'h0;
      widx_r <= 4'h0;
      fl_r <= `CAH_RST_FLAGS;
      bra_r <= `CAH_RST_WORD;
      ncyc_r <= `CAH_CYC_DP;
      load_req <= 1'b0;
      load_addr <= `CAH_RST_WORD;
      instr_done <= 1'b0;
      branch_valid <= 1'b0;
      branch_addr <= `CAH_RST_WORD;
      compact_state <= `CAH_RST_COMPACT;
      cond_flags <= `CAH_RST_FLAGS;
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      awaddr_r <= 8'h0;
      wdata_r <= `CAH_RST_WORD;
      wstrb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CAH_RESP_OKAY;
      rp1_r <= 1'b0;
      rp2_r <= 1'b0;
      araddr_r <= 8'h0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `CAH_RESP_OKAY;
      s_axi_rdata <= `CAH_RST_WORD;
    end else begin
      instr_done <= 1'b0;
      branch_valid <= 1'b0;
      // write channel: address and data taken in either order
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_do) begin
        aw_full_r <= 1'b0;
        w_full_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `CAH_RESP_OKAY;
        if (busy && (wr_win || awaddr_r == `CAH_OFF_INSTR || awaddr_r == `CAH_OFF_IADDR ||
            awaddr_r == `CAH_OFF_STATUS)) begin
          s_axi_bresp <= `CAH_RESP_SLVERR;
        end else if (issue) begin
          ir_r <= wdata_r[15:0];
          st_r <= ST_RUN;
          cnt_r <= 4'h1;
        end else if (awaddr_r == `CAH_OFF_IADDR) begin
          iaddr_r <= cah_strb(iaddr_r, wdata_r, wstrb_r);
        end else if (awaddr_r == `CAH_OFF_STATUS) begin
          cond_flags <= status_nw[`CAH_ST_FLAG_HI:`CAH_ST_FLAG_LO];
          compact_state <= status_nw[`CAH_ST_COMPACT];
        end else if (!wr_win && awaddr_r != `CAH_OFF_RESULT && awaddr_r != `CAH_OFF_TARGET &&
            awaddr_r != `CAH_OFF_CYCLES) begin
          s_axi_bresp <= `CAH_RESP_SLVERR;
        end
      end
      // read channel: two stages so window data comes from the register file
      if (s_axi_arvalid && s_axi_arready) begin
        rp1_r <= 1'b1;
        araddr_r <= s_axi_araddr;
      end
      if (rd_step) begin
        rp1_r <= 1'b0;
        rp2_r <= 1'b1;
      end
      if (rp2_r) begin
        rp2_r <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `CAH_RESP_OKAY;
        if (rd_win) begin
          s_axi_rdata <= rf_a;
        end else begin
          case (araddr_r)
            `CAH_OFF_INSTR: s_axi_rdata <= {16'h0, ir_r};
            `CAH_OFF_IADDR: s_axi_rdata <= iaddr_r;
            `CAH_OFF_STATUS: s_axi_rdata <= status_w;
            `CAH_OFF_RESULT: s_axi_rdata <= result_r;
            `CAH_OFF_TARGET: s_axi_rdata <= target_r;
            `CAH_OFF_CYCLES: s_axi_rdata <= {28'h0, cycles_r};
            default: begin
              s_axi_rdata <= 32'h0;
              s_axi_rresp <= `CAH_RESP_SLVERR;
            end
          endcase
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      // run: latch first-cycle outcome, wait out the cycle count and load
      if (busy) begin
        if (cnt_r != `CAH_CYC_MAX) begin
          cnt_r <= cnt_r + 4'h1;
        end
        if (first) begin
          res_r <= res_c;
          wb_r <= wb_c;
          widx_r <= rd_i;
          fl_r <= fl_c;
          br_r <= br_c;
          bra_r <= bra_c;
          t_r <= t_c;
          un_r <= un_c;
          ncyc_r <= ncyc_c;
          load_req <= ld_c;
          load_addr <= ld_ea;
        end
        if (load_req && load_valid) begin
          load_req <= 1'b0;
          res_r <= load_data;
        end
        if (fin) begin
          st_r <= ST_IDLE;
          cnt_r <= 4'h0;
          instr_done <= 1'b1;
          result_r <= fin_res;
          cycles_r <= cnt_r;
          unsup_r <= fin_un;
          cond_flags <= fin_fl;
          if (fin_br) begin
            branch_valid <= 1'b1;
            branch_addr <= fin_bra;
            target_r <= fin_bra;
            compact_state <= fin_t;
          end
        end
      end
    end
  end
endmodule // cah_decode_core

// ===== inc/cah_regs.vh
// Purpose: constants for the compact ALU / high-register / pc-load decoder
// Assumes: included by bare name from the decoder core and the bench
// Notes: offsets are byte addresses on the AXI4-Lite register bus
`ifndef CAH_REGS_VH
`define CAH_REGS_VH

// ****************************************
// register map and bus answers
// ****************************************
`define CAH_ADDR_W 8
`define CAH_OFF_INSTR 8'h00
`define CAH_OFF_IADDR 8'h04
`define CAH_OFF_STATUS 8'h08
`define CAH_OFF_RESULT 8'h0c
`define CAH_OFF_TARGET 8'h10
`define CAH_OFF_CYCLES 8'h14
`define CAH_WIN_BASE 2'h1
`define CAH_RESP_OKAY 2'h0
`define CAH_RESP_SLVERR 2'h2

// ****************************************
// status fields and reset values
// ****************************************
`define CAH_ST_BUSY 0
`define CAH_ST_COMPACT 1
`define CAH_ST_UNSUP 2
`define CAH_ST_FLAG_LO 28
`define CAH_ST_FLAG_HI 31
`define CAH_RST_FLAGS 4'h0
`define CAH_RST_COMPACT 1'b1
`define CAH_RST_WORD 32'h0000_0000

// ****************************************
// instruction fields
// ****************************************
`define CAH_FMT4_PAT 6'h10
`define CAH_FMT5_PAT 6'h11
`define CAH_FMT6_PAT 5'h09
`define CAH_OP_AND 4'h0
`define CAH_OP_XOR 4'h1
`define CAH_OP_SHL 4'h2
`define CAH_OP_SHR 4'h3
`define CAH_OP_SAR 4'h4
`define CAH_OP_ADC 4'h5
`define CAH_OP_SUBC 4'h6
`define CAH_OP_ROTR 4'h7
`define CAH_OP_TEST 4'h8
`define CAH_OP_RSUB 4'h9
`define CAH_OP_CSUB 4'ha
`define CAH_OP_CADD 4'hb
`define CAH_OP_OR 4'hc
`define CAH_OP_PROD 4'hd
`define CAH_OP_ANDN 4'he
`define CAH_OP_NOT 4'hf
`define CAH_HOP_ADD 2'h0
`define CAH_HOP_CSUB 2'h1
`define CAH_HOP_COPY 2'h2
`define CAH_HOP_BREX 2'h3
`define CAH_PC_IDX 4'hf

// ****************************************
// pc forms and cycle counts
// ****************************************
`define CAH_PC_AHEAD 32'h0000_0004
`define CAH_CLR_BIT0 32'hffff_fffe
`define CAH_CLR_BIT1 32'hffff_fffd
`define CAH_CYC_DP 4'h1
`define CAH_CYC_REGSHIFT 4'h2
`define CAH_CYC_PCWRITE 4'h3
`define CAH_CYC_LOAD 4'h3
`define CAH_CYC_MAX 4'hf

`endif

// ===== core/cah_regfile.v
// Purpose: sixteen-word register file, two read ports, one write port
// Assumes: single clock; read data registered, held when not enabled
// Notes: write and read of one word in one cycle returns the old word
`timescale 1ns/1ps
module cah_regfile #(
  parameter DW = 32,
  parameter AW = 4
) (
  input wire aclk,
  input wire re_a,
  input wire [AW-1:0] addr_a,
  output reg [DW-1:0] rdata_a,
  input wire re_b,
  input wire [AW-1:0] addr_b,
  output reg [DW-1:0] rdata_b,
  input wire we,
  input wire [AW-1:0] waddr,
  input wire [DW-1:0] wdata
);
  reg [DW-1:0] mem [0:(1<<AW)-1];

  always @(posedge aclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    if (re_a) begin
      rdata_a <= mem[addr_a];
    end
    if (re_b) begin
      rdata_b <= mem[addr_b];
    end
  end
endmodule // cah_regfile

// ===== tb/cah_decode_props.sv
// Purpose: port checks on the compact decoder
// Assumes: one clock aclk, synchronous active-low reset
// Notes: bound onto every cah_decode_core
`timescale 1ns/1ps
module cah_decode_props (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awready,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire load_req,
  input wire [31:0] load_addr,
  input wire load_valid,
  input wire busy,
  input wire instr_done,
  input wire branch_valid,
  input wire [31:0] branch_addr
);
  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_done_single: assert property (instr_done |=> !instr_done) else $error("done wider than a cycle");
  a_done_after_run: assert property (instr_done |-> !busy && $past(busy)) else $error("done off run end");
  a_busy_end_done: assert property ($fell(busy) |-> instr_done) else $error("run ended without done");
  a_branch_target: assert property (branch_valid |-> instr_done && !branch_addr[0]) else $error("bad branch");
  a_load_stable: assert property (load_req && !load_valid |=> load_req && $stable(load_addr))
    else $error("load request dropped or moved");
  a_load_word: assert property (load_req |-> load_addr[1:0] == 2'h0) else $error("load not word aligned");
  a_load_start: assert property ($rose(load_req) |-> busy && $past(busy)) else $error("load before run 2");
  a_load_end: assert property (load_req && load_valid |=> !load_req) else $error("load request stuck");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_wr_stall: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken early");
endmodule // cah_decode_props
bind cah_decode_core cah_decode_props u_props (.aclk, .aresetn, .s_axi_awready, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .load_req, .load_addr, .load_valid,
  .busy, .instr_done, .branch_valid, .branch_addr);

// ===== tb/compact_alu_hireg_pcload_decode_bench.sv
// Purpose: self-checking bench for the compact decoder
// Assumes: register window and load port of the core
// Notes: bench model holds register file and flags
`timescale 1ns/1ps
`include "cah_regs.vh"
module compact_alu_hireg_pcload_decode_bench;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_rvalid;
  logic s_axi_rready, load_req, load_valid, busy, instr_done, branch_valid, compact_state;
  logic s_axi_awready, s_axi_wready, s_axi_arready;
  logic [7:0] s_axi_awaddr, s_axi_araddr, w;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [3:0] s_axi_wstrb, cond_flags, f, m, fl;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp, h;
  logic [31:0] s_axi_wdata, s_axi_rdata, load_addr, load_data, branch_addr, ia, la, v, sv, ld;
  logic [31:0] r [16];
  logic [36:0] e;
  int errors, checks_done, dn, sn;
  cah_decode_core DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .load_req, .load_addr, .load_data, .load_valid, .busy, .instr_done, .branch_valid,
    .branch_addr, .compact_state, .cond_flags);
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    checks_done++;
    if (g !== x) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task automatic end_of_test;
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ga, gw;
    ga = 1'b0;
    gw = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(ga && gw)) begin
      @(posedge aclk);
      ga = ga | s_axi_awready;
      gw = gw | s_axi_wready;
      s_axi_awvalid <= !ga;
      s_axi_wvalid <= !gw;
    end
    while (!s_axi_bvalid) @(posedge aclk);
    s_axi_bready <= 1'b1;
    @(posedge aclk);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    v = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic ex(input logic [15:0] i);
    wr(`CAH_OFF_INSTR, {16'h0, i});
    do begin
      @(posedge aclk);
      if (load_req) la = load_addr;
      load_valid <= load_req && !load_valid;
    end while (busy);
  endtask
  function automatic logic [36:0] alu(input logic [3:0] op, input logic [31:0] d, input logic [31:0] s,
      input logic [3:0] fi);
    logic [31:0] a, b, q;
    logic [32:0] t;
    logic ci;
    a = d;
    b = ~s;
    ci = 1'b1;
    q = 32'h0;
    case (op)
      4'h0, 4'h8: q = d & s;
      4'h1: q = d ^ s;
      4'h2: q = s[7:0] > 31 ? 32'h0 : d << s[7:0];
      4'h3: q = s[7:0] > 31 ? 32'h0 : d >> s[7:0];
      4'h4: q = s[7:0] > 31 ? {32{d[31]}} : (d >> s[7:0]) | ({32{d[31]}} << (32 - s[7:0]));
      4'h5: begin
        b = s;
        ci = fi[1];
      end
      4'h6: ci = fi[1];
      4'h7: q = (d >> s[4:0]) | (d << (32 - s[4:0]));
      4'h9: a = 32'h0;
      4'hb: begin
        b = s;
        ci = 1'b0;
      end
      4'hc: q = d | s;
      4'hd: q = d * s;
      4'he: q = d & ~s;
      4'hf: q = ~s;
      default: ;
    endcase
    t = {1'b0, a} + {1'b0, b} + {32'h0, ci};
    if (op inside {4'h5, 4'h6, 4'h9, 4'ha, 4'hb}) begin
      q = t[31:0];
      fi[1] = t[32];
      fi[0] = (a[31] == b[31]) && (q[31] != a[31]);
    end
    return {!(op inside {4'h8, 4'ha, 4'hb}), q[31], q == 32'h0, fi[1:0], q};
  endfunction
  // ****************************************
  // stimulus
  // ****************************************
  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_awprot} = '0;
    {s_axi_arvalid, s_axi_rready, load_data, load_valid, aresetn, s_axi_arprot} = '0;
    s_axi_wstrb = 4'hf;
    v = $urandom(32'he062f36a);
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk({compact_state, cond_flags}, 32'h10);
    ia = $urandom & `CAH_CLR_BIT0;
    wr(`CAH_OFF_IADDR, ia);
    for (int n = 0; n < 16; n++) begin
      r[n] = $urandom;
      wr(8'h40 + 8'(4 * n), r[n]);
    end
    for (int p = 0; p < 2; p++) for (int op = 0; op < 16; op++) begin
      dn = $urandom % 8;
      sn = $urandom % 8;
      if (p) r[sn] = $urandom % 40;
      wr(8'h40 + 8'(4 * sn), r[sn]);
      f = 4'($urandom);
      wr(`CAH_OFF_STATUS, {f, 28'h2});
      e = alu(4'(op), r[dn], r[sn], f);
      ex({`CAH_FMT4_PAT, 4'(op), 3'(sn), 3'(dn)});
      if (e[36]) r[dn] = e[31:0];
      rd(8'h40 + 8'(4 * dn));
      chk(v, r[dn]);
      rd(`CAH_OFF_STATUS);
      m = op inside {2, 3, 4, 7, 13} ? 4'hc : 4'hf;
      chk(v[31:28] & m, e[35:32] & m);
      rd(`CAH_OFF_CYCLES);
      if (op != 13) chk(v, op inside {2, 3, 4, 7} ? 2 : 1);
    end
    fl = 4'h5;
    wr(`CAH_OFF_STATUS, {fl, 28'h2});
    for (int k = 0; k < 6; k++) begin
      h = k == 5 ? 2'h1 : 2'(1 + $urandom % 3);
      dn = (h[1] ? 8 : 0) + $urandom % 7;
      sn = k == 5 ? 15 : (h[0] ? 8 : 0) + $urandom % 8;
      sv = sn == 15 ? (ia + 4) & `CAH_CLR_BIT0 : r[sn];
      e = alu(4'ha, r[dn], sv, fl);
      ex({`CAH_FMT5_PAT, 2'(k % 3), h, 3'(sn), 3'(dn)});
      if (k % 3 == 0) r[dn] = r[dn] + sv;
      if (k % 3 == 2) r[dn] = sv;
      if (k % 3 == 1) fl = e[35:32];
      rd(8'h40 + 8'(4 * dn));
      chk(v, r[dn]);
      rd(`CAH_OFF_STATUS);
      chk(v[31:28], fl);
    end
    for (int b = 0; b < 2; b++) begin
      sn = b ? 9 : 2;
      r[sn] = ($urandom & `CAH_CLR_BIT0) | 32'(b);
      wr(8'h40 + 8'(4 * sn), r[sn]);
      ex({`CAH_FMT5_PAT, 2'h3, 1'b0, 1'(b), 3'(sn), 3'h0});
      chk(branch_addr, r[sn] & `CAH_CLR_BIT0);
      chk(compact_state, b);
      rd(`CAH_OFF_CYCLES);
      chk(v, 3);
    end
    for (int k = 0; k < 2; k++) begin
      ia = ($urandom & `CAH_CLR_BIT0) | 32'h2;
      wr(`CAH_OFF_IADDR, ia);
      w = k ? 8'($urandom) : 8'hff;
      ld = $urandom;
      load_data <= ld;
      ex({`CAH_FMT6_PAT, 3'h3, w});
      chk(la, ((ia + 4) & `CAH_CLR_BIT1) + {22'h0, w, 2'h0});
      rd(8'h4c);
      chk(v, ld);
    end
    ex(16'h0000);
    rd(`CAH_OFF_STATUS);
    chk(v[`CAH_ST_UNSUP], 1'b1);
    wr(8'h30, 32'h0);
    chk(resp, `CAH_RESP_SLVERR);
    rd(8'h30);
    chk(resp, `CAH_RESP_SLVERR);
    end_of_test;
  end
  initial begin
    #100000;
    errors++;
    end_of_test;
  end
endmodule // compact_alu_hireg_pcload_decode_bench
